/* hdl/spcsw_top.sv */
// Purpose: decode spindle command words 4/5, build status words 1/2
// Assumes: speed and droop are same-clock values; drive flags are pins
// Notes: avalon-mm slave, fixed one waitrequest cycle per access
//
// Decided for this implementation: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "spcsw_defines.svh"
module spcsw_top #(
	parameter int ZS_HOLD_CYC = `SPCSW_ZS_HOLD_CYC
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire spcsw_pkg::spcsw_drive_t drive_in,
	input wire logic [15:0] motor_speed,
	input wire logic [15:0] droop,
	input wire logic [15:0] inpos_width_param,
	input wire logic [15:0] zero_speed_level_param,
	input wire logic [15:0] grid_amount,
	output spcsw_pkg::spcsw_sel_t sel_out,
	output logic [15:0] grid_out,
	output logic grid_valid
);
	logic [1:0] rst_sync_q;
	logic rst_n;
	spcsw_pkg::spcsw_drive_t drv_m_q, drv_q;
	logic [15:0] cmd4_q, cmd5_q, stat1_q, stat2_q;
	logic orc_prev_q, z_prev_q, zcn_q, inp_q, zs_q;
	logic ack_q;
	logic [31:0] zs_cnt_q;
	spcsw_pkg::spcsw_zs_t zs_st_q;
	logic [15:0] abs_speed;
	logic wr_cmd5;

	function automatic logic [15:0] abs16(input logic [15:0] v);
		abs16 = v[15] ? 16'(-v) : v;
	endfunction : abs16

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) rst_sync_q <= 2'h0;
		else rst_sync_q <= {rst_sync_q[0], 1'h1};
	end
	assign rst_n = rst_sync_q[1];

	// drive flags come from pins: two-stage sync
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			drv_m_q <= '0;
			drv_q <= '0;
		end else begin
			drv_m_q <= drive_in;
			drv_q <= drv_m_q;
		end
	end

	// bus: one wait cycle, then ack; unmapped reads zero, writes dropped
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) ack_q <= 1'h0;
		else ack_q <= (avs_read || avs_write) && !ack_q;
	end
	// registered inverse of ack: output straight from a flop, no bus glitch
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) avs_waitrequest <= 1'h1;
		else avs_waitrequest <= !((avs_read || avs_write) && !ack_q);
	end
	assign wr_cmd5 = ack_q && avs_write && avs_address == `SPCSW_ADDR_CMD5;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cmd4_q <= 16'h0000;
			cmd5_q <= 16'h0000;
		end else if (ack_q && avs_write) begin
			if (avs_address == `SPCSW_ADDR_CMD4)
				cmd4_q <= avs_writedata[15:0] & `SPCSW_CMD4_MASK;
			if (wr_cmd5)
				cmd5_q <= avs_writedata[15:0] & `SPCSW_CMD5_MASK;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) avs_readdata <= 32'h00000000;
		else if (avs_read && !ack_q) begin
			case (avs_address)
				`SPCSW_ADDR_CMD4: avs_readdata <= {16'h0000, cmd4_q};
				`SPCSW_ADDR_CMD5: avs_readdata <= {16'h0000, cmd5_q};
				`SPCSW_ADDR_STAT1: avs_readdata <= {16'h0000, stat1_q};
				`SPCSW_ADDR_STAT2: avs_readdata <= {16'h0000, stat2_q};
				default: avs_readdata <= 32'h00000000;
			endcase
		end
	end

	// droop within width, servo state ignored
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) inp_q <= 1'h0;
		else inp_q <= abs16(droop) <= inpos_width_param;
	end

	// selections; ratio swap does not keep spindle angle
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) sel_out <= '0;
		else begin
			if (cmd4_q[`SPCSW_B_GKC] && !drv_q.interp_mode)
				sel_out.gear_idx <= {cmd4_q[`SPCSW_B_GR2], cmd4_q[`SPCSW_B_GR1]};
			sel_out.excitation_two <= cmd5_q[`SPCSW_B_PY2];
			if (inp_q)
				sel_out.gain_set_two <= cmd5_q[`SPCSW_B_VG2];
			sel_out.boost <= cmd5_q[`SPCSW_B_HOLDING_FORCE_BOOST];
		end
	end

	// index pulse passed flag; z edge wins over redetect clear
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			orc_prev_q <= 1'h0;
			z_prev_q <= 1'h0;
			zcn_q <= 1'h0;
			grid_out <= 16'h0000;
			grid_valid <= 1'h0;
		end else begin
			orc_prev_q <= cmd5_q[`SPCSW_B_ORC];
			z_prev_q <= drv_q.z_phase;
			grid_valid <= 1'h0;
			// set on z phase rise, send grid only while not yet set
			if (drv_q.z_phase && !z_prev_q) begin
				if (!zcn_q) begin
					grid_out <= grid_amount;
					grid_valid <= 1'h1;
				end
				zcn_q <= 1'h1;
			end else if (cmd5_q[`SPCSW_B_ORC] && !orc_prev_q) begin
				zcn_q <= 1'h0;
			end
		end
	end

	assign abs_speed = abs16(motor_speed);

	// zero speed: set below level, clear after hold at or above level, entered at level+15
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			zs_st_q <= spcsw_pkg::SPCSW_ZS_IDLE;
			zs_q <= 1'h0;
			zs_cnt_q <= 32'h00000000;
		end else begin
			case (zs_st_q)
				spcsw_pkg::SPCSW_ZS_IDLE: begin
					zs_q <= 1'h0;
					if (abs_speed < zero_speed_level_param) begin
						zs_q <= 1'h1;
						zs_st_q <= spcsw_pkg::SPCSW_ZS_LOW;
					end
				end
				spcsw_pkg::SPCSW_ZS_LOW: begin
					zs_cnt_q <= 32'h00000000;
					if (17'(abs_speed) >= 17'(zero_speed_level_param) + 17'(`SPCSW_ZS_HYST_RPM))
						zs_st_q <= spcsw_pkg::SPCSW_ZS_HOLD;
				end
				spcsw_pkg::SPCSW_ZS_HOLD: begin
					if (abs_speed < zero_speed_level_param)
						zs_st_q <= spcsw_pkg::SPCSW_ZS_LOW;
					else if (zs_cnt_q >= 32'(ZS_HOLD_CYC - 1)) begin
						zs_q <= 1'h0;
						zs_st_q <= spcsw_pkg::SPCSW_ZS_IDLE;
					end else
						zs_cnt_q <= zs_cnt_q + 32'h00000001;
				end
				default: zs_st_q <= spcsw_pkg::SPCSW_ZS_IDLE;
			endcase
		end
	end

	// status words; reserved bits zero; servo-off follow-up is the controller's job
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			stat1_q <= 16'h0000;
			stat2_q <= 16'h0000;
		end else begin
			stat1_q <= 16'h0000;
			stat1_q[`SPCSW_S1_RDY] <= drv_q.ready_on;
			stat1_q[`SPCSW_S1_SRV] <= drv_q.servo_on;
			stat1_q[`SPCSW_S1_ALM] <= drv_q.alarm;
			stat1_q[`SPCSW_S1_TL +: `SPCSW_S1_TL_W] <= drv_q.torque_lim;
			stat1_q[`SPCSW_S1_INP] <= inp_q;
			stat1_q[`SPCSW_S1_WRN] <= drv_q.warning;
			stat2_q <= 16'h0000;
			stat2_q[`SPCSW_S2_ZCN] <= zcn_q;
			stat2_q[`SPCSW_S2_ZS] <= zs_q;
			stat2_q[`SPCSW_S2_EMG] <= drv_q.ext_emergency_stop;
		end
	end

	// gear follows command one cycle later
	property p_gear;
		@(posedge sys_clk) disable iff (!rst_n)
		(cmd4_q[`SPCSW_B_GKC] && !drv_q.interp_mode) |=>
			sel_out.gear_idx == $past({cmd4_q[`SPCSW_B_GR2], cmd4_q[`SPCSW_B_GR1]});
	endproperty
	a_gear: assert property (p_gear) else $error("gear not applied");

	property p_interp;
		@(posedge sys_clk) disable iff (!rst_n)
		drv_q.interp_mode |=> $stable(sel_out.gear_idx);
	endproperty
	a_interp: assert property (p_interp) else $error("gear changed in interp");

	property p_gain;
		@(posedge sys_clk) disable iff (!rst_n)
		!inp_q |=> $stable(sel_out.gain_set_two);
	endproperty
	a_gain: assert property (p_gain) else $error("gain changed out of position");

	property p_exc;
		@(posedge sys_clk) disable iff (!rst_n)
		1'b1 |=> sel_out.excitation_two == $past(cmd5_q[`SPCSW_B_PY2]);
	endproperty
	a_exc: assert property (p_exc) else $error("excitation select wrong");

	property p_orc;
		@(posedge sys_clk) disable iff (!rst_n)
		$rose(cmd5_q[`SPCSW_B_ORC]) && !(drv_q.z_phase && !z_prev_q) |=> ##1 !stat2_q[`SPCSW_S2_ZCN];
	endproperty
	a_orc: assert property (p_orc) else $error("redetect did not clear");

	property p_grid;
		@(posedge sys_clk) disable iff (!rst_n)
		$rose(zcn_q) |-> grid_valid && grid_out == $past(grid_amount);
	endproperty
	a_grid: assert property (p_grid) else $error("grid not sent on rise");

	property p_emg;
		@(posedge sys_clk) disable iff (!rst_n)
		drv_q.ext_emergency_stop |=> stat2_q[`SPCSW_S2_EMG];
	endproperty
	a_emg: assert property (p_emg) else $error("emergency stop not shown");

	property p_zs;
		@(posedge sys_clk) disable iff (!rst_n)
		(abs_speed < zero_speed_level_param) |=> zs_q;
	endproperty
	a_zs: assert property (p_zs) else $error("zero speed not set");

	property p_tl;
		@(posedge sys_clk) disable iff (!rst_n)
		1'b1 |=> stat1_q[`SPCSW_S1_TL +: `SPCSW_S1_TL_W] == $past(drv_q.torque_lim);
	endproperty
	a_tl: assert property (p_tl) else $error("torque echo wrong");

	property p_boost;
		@(posedge sys_clk) disable iff (!rst_n)
		1'b1 |=> sel_out.boost == $past(cmd5_q[`SPCSW_B_HOLDING_FORCE_BOOST]);
	endproperty
	a_boost: assert property (p_boost) else $error("boost not following request");

	property p_gain_set;
		@(posedge sys_clk) disable iff (!rst_n)
		inp_q |=> sel_out.gain_set_two == $past(cmd5_q[`SPCSW_B_VG2]);
	endproperty
	a_gain_set: assert property (p_gain_set) else $error("gain set not applied");

	property p_ready;
		@(posedge sys_clk) disable iff (!rst_n)
		1'b1 |=> stat1_q[`SPCSW_S1_RDY] == $past(drv_q.ready_on);
	endproperty
	a_ready: assert property (p_ready) else $error("ready flag wrong");

	property p_servo;
		@(posedge sys_clk) disable iff (!rst_n)
		1'b1 |=> stat1_q[`SPCSW_S1_SRV] == $past(drv_q.servo_on);
	endproperty
	a_servo: assert property (p_servo) else $error("servo flag wrong");

	property p_alarm;
		@(posedge sys_clk) disable iff (!rst_n)
		1'b1 |=> stat1_q[`SPCSW_S1_ALM] == $past(drv_q.alarm);
	endproperty
	a_alarm: assert property (p_alarm) else $error("alarm flag wrong");

	property p_warn;
		@(posedge sys_clk) disable iff (!rst_n)
		1'b1 |=> stat1_q[`SPCSW_S1_WRN] == $past(drv_q.warning);
	endproperty
	a_warn: assert property (p_warn) else $error("warning flag wrong");

	property p_inp;
		@(posedge sys_clk) disable iff (!rst_n)
		1'b1 |=> inp_q == $past(abs16(droop) <= inpos_width_param);
	endproperty
	a_inp: assert property (p_inp) else $error("in position wrong");

	property p_zcn;
		@(posedge sys_clk) disable iff (!rst_n)
		(drv_q.z_phase && !z_prev_q) |=> zcn_q;
	endproperty
	a_zcn: assert property (p_zcn) else $error("index passed not set");

	property p_s1_rsvd;
		@(posedge sys_clk) disable iff (!rst_n)
		1'b1 |-> (stat1_q & ~`SPCSW_S1_MASK) == 16'h0000;
	endproperty
	a_s1_rsvd: assert property (p_s1_rsvd) else $error("status1 reserved bit set");

	property p_s2_rsvd;
		@(posedge sys_clk) disable iff (!rst_n)
		1'b1 |-> (stat2_q & ~`SPCSW_S2_MASK) == 16'h0000;
	endproperty
	a_s2_rsvd: assert property (p_s2_rsvd) else $error("status2 reserved bit set");

	property p_cmd_rsvd;
		@(posedge sys_clk) disable iff (!rst_n)
		1'b1 |-> (cmd4_q & ~`SPCSW_CMD4_MASK) == 16'h0000
			&& (cmd5_q & ~`SPCSW_CMD5_MASK) == 16'h0000;
	endproperty
	a_cmd_rsvd: assert property (p_cmd_rsvd) else $error("command reserved bit kept");

	property p_grid_pulse;
		@(posedge sys_clk) disable iff (!rst_n)
		grid_valid |=> !grid_valid;
	endproperty
	a_grid_pulse: assert property (p_grid_pulse) else $error("grid pulse too long");

	property p_zs_hold;
		@(posedge sys_clk) disable iff (!rst_n)
		zs_st_q == spcsw_pkg::SPCSW_ZS_HOLD |-> zs_q;
	endproperty
	a_zs_hold: assert property (p_zs_hold) else $error("zero speed dropped early");

	property p_zs_fell;
		@(posedge sys_clk) disable iff (!rst_n)
		$fell(zs_q) |-> $past(zs_st_q) == spcsw_pkg::SPCSW_ZS_HOLD;
	endproperty
	a_zs_fell: assert property (p_zs_fell) else $error("zero speed cleared outside hold");

	property p_gear_keep;
		@(posedge sys_clk) disable iff (!rst_n)
		!cmd4_q[`SPCSW_B_GKC] |=> $stable(sel_out.gear_idx);
	endproperty
	a_gear_keep: assert property (p_gear_keep) else $error("gear changed without command");
endmodule : spcsw_top
`default_nettype wire

/* inc/spcsw_defines.svh */
// Purpose: constants for the spindle command/status word block
// Assumes: 50 MHz sys_clk
// Notes: register map offsets are byte addresses on the avalon slave
`ifndef SPCSW_DEFINES_SVH
`define SPCSW_DEFINES_SVH
`define SPCSW_ADDR_CMD4 4'h0
`define SPCSW_ADDR_CMD5 4'h4
`define SPCSW_ADDR_STAT1 4'h8
`define SPCSW_ADDR_STAT2 4'hC
`define SPCSW_ADDR_CFG 4'h0
`define SPCSW_CMD4_MASK 16'h0070
`define SPCSW_CMD5_MASK 16'h7800
`define SPCSW_B_GKC 4
`define SPCSW_B_GR1 5
`define SPCSW_B_GR2 6
`define SPCSW_B_PY2 11
`define SPCSW_B_VG2 12
`define SPCSW_B_ORC 13
`define SPCSW_B_HOLDING_FORCE_BOOST 14
`define SPCSW_S1_RDY 0
`define SPCSW_S1_SRV 1
`define SPCSW_S1_ALM 7
`define SPCSW_S1_TL 8
`define SPCSW_S1_INP 12
`define SPCSW_S1_WRN 15
`define SPCSW_S2_ZCN 0
`define SPCSW_S2_ZS 3
`define SPCSW_S2_EMG 7
`define SPCSW_S1_TL_W 3
`define SPCSW_S1_MASK 16'h9783
`define SPCSW_S2_MASK 16'h0089
`define SPCSW_CLK_HZ 50000000
`define SPCSW_ZS_HOLD_MS 200
`define SPCSW_ZS_HYST_RPM 16'h000F
`define SPCSW_ZS_HOLD_CYC ((`SPCSW_ZS_HOLD_MS * (`SPCSW_CLK_HZ / 1000)))
`endif

/* inc/spcsw_pkg.sv */
// Purpose: types for the spindle command/status word block
// Assumes: included defines
// Notes: none
package spcsw_pkg;
	typedef struct packed {
		logic [2:0] torque_lim;
		logic ready_on;
		logic servo_on;
		logic alarm;
		logic warning;
		logic ext_emergency_stop;
		logic z_phase;
		logic interp_mode;
	} spcsw_drive_t;
	typedef struct packed {
		logic [1:0] gear_idx;
		logic excitation_two;
		logic gain_set_two;
		logic boost;
	} spcsw_sel_t;
	typedef enum logic [2:0] {
		SPCSW_ZS_IDLE = 3'b001,
		SPCSW_ZS_LOW = 3'b010,
		SPCSW_ZS_HOLD = 3'b100
	} spcsw_zs_t;
endpackage : spcsw_pkg

/* testbench/spcsw_ctrl_model.sv */
// Purpose: controller side of the word exchange
// Assumes: tasks entered only from the bench's main sequence
// Notes: no local bus timeout, the bench timeout ends any hang
`timescale 1ns/10ps
`default_nettype none
module spcsw_ctrl_model (
	input wire logic sys_clk,
	input wire logic avs_waitrequest,
	input wire logic [31:0] avs_readdata,
	output logic [3:0] avs_address,
	output logic avs_read,
	output logic avs_write,
	output logic [31:0] avs_writedata,
	input wire logic [15:0] actual_pos,
	output logic [15:0] pos_cmd
);
	logic srv_q;
	initial begin
		{avs_address, avs_read, avs_write, avs_writedata} = '0;
		srv_q = 1'b0;
		pos_cmd = 16'h0000;
	end
	always @(posedge sys_clk) begin
		if (!srv_q) begin
			pos_cmd <= actual_pos;
		end
	end
	task bus_wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		avs_address <= a;
		avs_writedata <= {16'h0000, d};
		avs_write <= 1'b1;
		do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
	endtask : bus_wr
	task bus_rd(input logic [3:0] a, output logic [15:0] q);
		@(posedge sys_clk);
		avs_address <= a;
		avs_read <= 1'b1;
		do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata[15:0];
		if (a == 4'h8) begin
			srv_q = q[1];
		end
		avs_read <= 1'b0;
	endtask : bus_rd
endmodule : spcsw_ctrl_model
`default_nettype wire

/* testbench/spindle_command_status_words_bench.sv */
// Purpose: self-checking bench for spcsw_top
// Assumes: zero-speed hold shortened to 20 cycles
// Notes: bus traffic goes through the controller model
`timescale 1ns/10ps
`default_nettype none
module spindle_command_status_words_bench;
	localparam int HOLD = 20;
	logic sys_clk, reset_n, avs_read, avs_write, avs_waitrequest, grid_valid;
	logic [3:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata;
	logic [15:0] spd, drp, wid, lvl, grid, grid_out, apos;
	spcsw_pkg::spcsw_drive_t drv;
	spcsw_pkg::spcsw_sel_t sel;
	int errors = 0;
	int n_tests = 0;
	int cyc_n = 0;
	spcsw_top #(.ZS_HOLD_CYC(HOLD)) spcsw_top_inst (.sys_clk(sys_clk), .reset_n(reset_n),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .drive_in(drv), .motor_speed(spd),
		.droop(drp), .inpos_width_param(wid), .zero_speed_level_param(lvl),
		.grid_amount(grid), .sel_out(sel), .grid_out(grid_out), .grid_valid(grid_valid));
	spcsw_ctrl_model spcsw_ctrl_model_inst (.sys_clk(sys_clk),
		.avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .actual_pos(apos), .pos_cmd());
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	task stop_test;
		if (errors == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : stop_test
	// hang guard, the run needs well under a thousand cycles
	always @(posedge sys_clk) begin
		cyc_n++;
		if (cyc_n == 3000) begin
			errors++;
			stop_test();
		end
	end
	task cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : cyc
	task chk(input string nm, input logic [15:0] s, input logic [15:0] e);
		n_tests++;
		if (s !== e) begin
			errors++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task wr(input logic [3:0] a, input logic [15:0] d);
		spcsw_ctrl_model_inst.bus_wr(a, d);
	endtask : wr
	task rc(input logic [3:0] a, input logic [15:0] e, input string nm);
		logic [15:0] q;
		spcsw_ctrl_model_inst.bus_rd(a, q);
		chk(nm, q, e);
	endtask : rc
	task t_stat;
		@(posedge sys_clk);
		drv <= '{3'b101, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
		wid <= 16'h0005;
		drp <= 16'h0005;
		cyc(5);
		rc(4'h8, 16'h1581, "status1");
		drv <= '{3'b010, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
		drp <= 16'hFFFA;
		cyc(5);
		rc(4'h8, 16'h8202, "status1");
		wr(4'h8, 16'hFFFF);
		rc(4'h8, 16'h8202, "status1 ro");
		rc(4'h2, 16'h0000, "unmapped");
	endtask : t_stat
	task t_gear;
		for (int g = 3; g >= 0; g--) begin
			wr(4'h0, 16'h0010 | (16'(g) << 5));
			cyc(2);
			chk("gear", {14'h0, sel.gear_idx}, 16'(g));
		end
		drv.interp_mode <= 1'b1;
		cyc(4);
		wr(4'h0, 16'h0070);
		cyc(3);
		chk("gear", {14'h0, sel.gear_idx}, 16'h0000);
		drv.interp_mode <= 1'b0;
		cyc(5);
		chk("gear", {14'h0, sel.gear_idx}, 16'h0003);
		wr(4'h0, 16'h0000);
	endtask : t_gear
	task t_cmd5;
		drp <= 16'h0000;
		cyc(3);
		wr(4'h4, 16'h5800);
		cyc(2);
		chk("sel", {11'h0, sel}, 16'h001F);
		drp <= 16'h0064;
		cyc(4);
		wr(4'h4, 16'h0000);
		cyc(2);
		chk("sel", {11'h0, sel}, 16'h001A);
		drp <= 16'h0000;
		cyc(5);
		chk("sel", {11'h0, sel}, 16'h0018);
	endtask : t_cmd5
	task t_zcn;
		int n;
		n = 0;
		@(posedge sys_clk);
		grid <= 16'hA5C3;
		drv.z_phase <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
		end while (grid_valid !== 1'b1 && n < 12);
		chk("grid_valid", {15'h0, grid_valid}, 16'h0001);
		chk("grid_out", grid_out, 16'hA5C3);
		drv.z_phase <= 1'b0;
		rc(4'hC, 16'h0001, "status2");
		wr(4'h4, 16'h2000);
		cyc(2);
		rc(4'hC, 16'h0000, "status2");
		wr(4'h4, 16'h0000);
	endtask : t_zcn
	task t_zs;
		lvl <= 16'h0064;
		spd <= 16'hFFCE;
		drv.ext_emergency_stop <= 1'b1;
		cyc(5);
		rc(4'hC, 16'h0088, "status2");
		// just under the hysteresis band, must not start the hold
		spd <= 16'h0072;
		cyc(40);
		rc(4'hC, 16'h0088, "status2");
		spd <= 16'h0073;
		cyc(8);
		rc(4'hC, 16'h0088, "status2");
		cyc(HOLD + 5);
		rc(4'hC, 16'h0080, "status2");
		drv.ext_emergency_stop <= 1'b0;
		cyc(5);
		rc(4'hC, 16'h0000, "status2");
	endtask : t_zs
	initial begin
		reset_n = 1'b0;
		drv = '0;
		{spd, drp, wid, lvl, grid, apos} = '0;
		cyc(5);
		reset_n <= 1'b1;
		cyc(3);
		t_stat();
		t_gear();
		t_cmd5();
		t_zcn();
		t_zs();
		stop_test();
	end
endmodule : spindle_command_status_words_bench
`default_nettype wire
